// ---- pkg/thread_exception_control_consts.svh ----
// offsets, selectors, field positions, reset values for thread control
`ifndef THREAD_EXCEPTION_CONTROL_CONSTS_SVH
`define THREAD_EXCEPTION_CONTROL_CONSTS_SVH
`define ARF_TYPE_CONTROL 4'h8
`define ARF_TYPE_STATE 4'h7
`define ARF_REGNUM_ZERO 4'h0
`define CTRL_SUB_GENERAL 5'h00
`define CTRL_SUB_EXCEPTION 5'h04
`define CTRL_SUB_SAVED_PTR 5'h08
`define CTRL_SUB_RESERVED 5'h0C
`define STATE_SUB_DISPATCH_MASK 5'h08
`define STATE_SUB_GROUPED_MASK 5'h0C
`define OFFS_GENERAL_CONTROL 32'h0000_0000
`define OFFS_EXCEPTION_ENABLE_STATUS 32'h0000_0004
`define OFFS_SAVED_APPLICATION_POINTER 32'h0000_0008
`define BIT_MASTER_EXCEPTION 31
`define BIT_BP_SUPPRESS 15
`define BIT_DF_DENORM 6
`define BIT_ROUND_HI 5
`define BIT_ROUND_LO 4
`define BIT_MASK_SELECT 3
`define BIT_UNIFORM_FLOW 2
`define BIT_ACCUM_DISABLE 1
`define BIT_SINGLE_FLOAT 0
`define EXC_IDX_BREAKPOINT 15
`define EXC_STATUS_LSB 16
`define MASK_GROUP_WIDTH 4
`define RST_WORD 32'h0000_0000
`define RST_HALF 16'h0000
`define RST_BIT 1'b0
`define RST_ROUND 2'h0
`endif

// ---- pkg/thread_exception_control_pkg.sv ----
// types shared by the thread exception control block
package thread_exception_control_pkg;
  typedef enum logic [1:0] {
    ROUND_NEAREST_EVEN = 2'h0,
    ROUND_UPWARD = 2'h1,
    ROUND_DOWNWARD = 2'h2,
    ROUND_TOWARD_ZERO = 2'h3
  } round_mode_t;

  // values loaded by the thread dispatcher at thread start
  typedef struct packed {
    logic [31:0] dispatch_channel_mask;
    round_mode_t round_mode;
    logic df_denorm_keep;
    logic mask_select;
    logic uniform_flow;
    logic single_float_behaviour;
    logic [15:0] exc_enable;
  } dispatch_init_t;

  // architecture register operand access
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] reg_type;
    logic [3:0] reg_num;
    logic [4:0] sub_reg;
    logic [31:0] wdata;
  } arf_req_t;

  // floating point and execution modes seen by the pipeline
  typedef struct packed {
    round_mode_t round_mode;
    logic df_flush_denorm;
    logic single_float_behaviour;
    logic uniform_flow;
    logic mask_select;
    logic accum_disable;
  } exec_modes_t;

  typedef struct packed {
    logic [31:0] disp_mask;
    logic [31:0] vmask;
    logic [31:0] emask;
    logic master;
    logic bp_suppress;
    logic df_denorm_keep;
    round_mode_t round_mode;
    logic mask_select;
    logic uniform_flow;
    logic accum_disable;
    logic single_float_behaviour;
    logic [15:0] exc_enable;
    logic [15:0] exc_status;
    logic [31:0] saved_ptr;
    logic [31:0] entry_ptr;
    logic [31:0] rdata;
    logic rvalid;
    logic redirect;
    logic [31:0] redirect_ip;
  } state_t;
endpackage : thread_exception_control_pkg

// ---- logic/grouped_mask_former.sv ----
// forms the grouped channel mask: each nibble is the OR of its dispatch nibble
`timescale 1ns/1ps
module grouped_mask_former
#(
  parameter int WIDTH = 32,
  parameter int GROUP = 4
)
(
  input wire logic [WIDTH-1:0] mask_in,
  output logic [WIDTH-1:0] grouped_out
);
  // one OR per group, replicated over the group's bits
  genvar g;
  generate
    for (g = 0; g < WIDTH / GROUP; g++)
    begin : g_group
      assign grouped_out[g*GROUP +: GROUP] = {GROUP{|mask_in[g*GROUP +: GROUP]}};
    end
  endgenerate
endmodule : grouped_mask_former

// ---- logic/thread_exception_control.sv ----
// per-thread control register, masks and exception redirect logic
`timescale 1ns/1ps
`include "thread_exception_control_consts.svh"

// Notes on behaviour
// - dispatch mask held, seeds execution mask
// - grouped mask ORs each nibble, seeds mask
// - control register type 1000b, four words
// - selectors 00000b, 00100b, 01000b; others reserved
// - fourth word drops writes, reads undefined
// - low enable bits gate handler jump
// - high status bits record every event
// - one bit per exception, priority by position
// - event saves pointer, sets master, jumps
// - master write zero from one returns
// - global handler pointer hidden from threads
// - suppress lets breakpoint pass, self-clears
// - suppress ignored in handler or disabled
// - denorm bit zero flushes, one keeps
// - two-bit rounding field selects mode
// - mask select picks dispatch or grouped
// - uniform flow makes branches move together
// - accumulator disable blocks implicit updates only
// - dispatcher loads float and flow fields
// - breakpoint enable bit 15 gates breakpoints
// - bit 0 selects single float behaviour
module thread_exception_control
  import thread_exception_control_pkg::*;
#(
  parameter int EXC_COUNT = 16
)
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic dispatch_valid_in,
  input wire dispatch_init_t dispatch_init_in,
  input wire arf_req_t arf_req_in,
  output logic [31:0] arf_rdata_out,
  output logic arf_rvalid_out,
  input wire logic [EXC_COUNT-1:0] exc_event_in,
  input wire logic bp_condition_in,
  input wire logic [31:0] exc_ip_in,
  input wire logic handler_entry_load_in,
  input wire logic [31:0] handler_entry_pointer_in,
  input wire logic accum_write_request_in,
  input wire logic accum_explicit_dst_in,
  output logic accum_write_enable_out,
  output logic bp_pass_out,
  output logic redirect_out,
  output logic [31:0] redirect_ip_out,
  output logic master_exception_out,
  output logic [31:0] exec_mask_out,
  output exec_modes_t exec_modes_out
);
  state_t state_reg;
  state_t state_next;
  logic [31:0] grouped_mask;
  logic [31:0] rd_word;
  logic [EXC_COUNT-1:0] evt;
  logic hit_ctrl;
  logic hit_state;
  logic wr;
  logic bp_armed;
  logic suppressing;
  logic take;
  logic ret;

  // grouped mask from whatever dispatch mask is arriving
  grouped_mask_former #(
    .WIDTH(32),
    .GROUP(`MASK_GROUP_WIDTH)
  ) u_grouped (
    .mask_in(dispatch_init_in.dispatch_channel_mask),
    .grouped_out(grouped_mask)
  );

  // operand decode: register number must be zero for both register types
  assign hit_ctrl = arf_req_in.valid && arf_req_in.reg_type == `ARF_TYPE_CONTROL
    && arf_req_in.reg_num == `ARF_REGNUM_ZERO;
  assign hit_state = arf_req_in.valid && arf_req_in.reg_type == `ARF_TYPE_STATE
    && arf_req_in.reg_num == `ARF_REGNUM_ZERO;
  assign wr = arf_req_in.write;

  // breakpoint suppress only counts outside the handler with breakpoints on
  assign bp_armed = !state_reg.master && state_reg.exc_enable[`EXC_IDX_BREAKPOINT];
  assign suppressing = bp_condition_in && bp_armed && state_reg.bp_suppress;

  // breakpoint takes its own bit; a suppressed one is no event at all
  always_comb
  begin
    evt = exc_event_in;
    evt[`EXC_IDX_BREAKPOINT] = bp_condition_in && !suppressing;
  end

  // jump only from normal state and only for an enabled event
  assign take = !state_reg.master && |(evt & state_reg.exc_enable);
  // software writing zero to the master bit while it is set
  assign ret = hit_ctrl && wr && arf_req_in.sub_reg == `CTRL_SUB_GENERAL
    && state_reg.master && !arf_req_in.wdata[`BIT_MASTER_EXCEPTION];

  // read mux; reserved bits and unmapped selectors read as zero
  always_comb
  begin
    rd_word = `RST_WORD;
    if (hit_ctrl)
    begin
      case (arf_req_in.sub_reg)
        `CTRL_SUB_GENERAL:
        begin
          rd_word[`BIT_MASTER_EXCEPTION] = state_reg.master;
          rd_word[`BIT_BP_SUPPRESS] = state_reg.bp_suppress;
          rd_word[`BIT_DF_DENORM] = state_reg.df_denorm_keep;
          rd_word[`BIT_ROUND_HI:`BIT_ROUND_LO] = state_reg.round_mode;
          rd_word[`BIT_MASK_SELECT] = state_reg.mask_select;
          rd_word[`BIT_UNIFORM_FLOW] = state_reg.uniform_flow;
          rd_word[`BIT_ACCUM_DISABLE] = state_reg.accum_disable;
          rd_word[`BIT_SINGLE_FLOAT] = state_reg.single_float_behaviour;
        end
        `CTRL_SUB_EXCEPTION: rd_word = {state_reg.exc_status, state_reg.exc_enable};
        `CTRL_SUB_SAVED_PTR: rd_word = state_reg.saved_ptr;
        // the reserved word reads zero, any value is allowed there
        default: rd_word = `RST_WORD;
      endcase
    end
    else if (hit_state)
    begin
      case (arf_req_in.sub_reg)
        `STATE_SUB_DISPATCH_MASK: rd_word = state_reg.disp_mask;
        `STATE_SUB_GROUPED_MASK: rd_word = state_reg.vmask;
        default: rd_word = `RST_WORD;
      endcase
    end
  end

  // next state: software writes first, hardware events after so they win, except a software suppress set beats the self-clear
  always_comb
  begin
    state_next = state_reg;
    state_next.redirect = 1'b0;
    state_next.rvalid = arf_req_in.valid && !wr && (hit_ctrl || hit_state);
    if (arf_req_in.valid && !wr)
    begin
      state_next.rdata = rd_word;
    end
    // software writes to control words; reserved word writes fall through
    if (hit_ctrl && wr)
    begin
      case (arf_req_in.sub_reg)
        `CTRL_SUB_GENERAL:
        begin
          state_next.bp_suppress = arf_req_in.wdata[`BIT_BP_SUPPRESS];
          state_next.df_denorm_keep = arf_req_in.wdata[`BIT_DF_DENORM];
          state_next.round_mode = round_mode_t'(arf_req_in.wdata[`BIT_ROUND_HI:`BIT_ROUND_LO]);
          state_next.mask_select = arf_req_in.wdata[`BIT_MASK_SELECT];
          state_next.uniform_flow = arf_req_in.wdata[`BIT_UNIFORM_FLOW];
          state_next.accum_disable = arf_req_in.wdata[`BIT_ACCUM_DISABLE];
          state_next.single_float_behaviour = arf_req_in.wdata[`BIT_SINGLE_FLOAT];
        end
        `CTRL_SUB_EXCEPTION:
        begin
          state_next.exc_enable = arf_req_in.wdata[15:0];
          state_next.exc_status = arf_req_in.wdata[31:16];
        end
        `CTRL_SUB_SAVED_PTR: state_next.saved_ptr = arf_req_in.wdata;
        default: state_next.saved_ptr = state_reg.saved_ptr;
      endcase
    end
    // state register mask words
    if (hit_state && wr)
    begin
      case (arf_req_in.sub_reg)
        `STATE_SUB_DISPATCH_MASK: state_next.disp_mask = arf_req_in.wdata;
        `STATE_SUB_GROUPED_MASK: state_next.vmask = arf_req_in.wdata;
        default: state_next.disp_mask = state_reg.disp_mask;
      endcase
    end
    // hardware self-clear of suppress, unless software sets it this cycle
    if (suppressing && !(hit_ctrl && wr && arf_req_in.sub_reg == `CTRL_SUB_GENERAL
        && arf_req_in.wdata[`BIT_BP_SUPPRESS]))
    begin
      state_next.bp_suppress = 1'b0;
    end
    // status records every event, even disabled ones; set beats clear
    state_next.exc_status = state_next.exc_status | evt;
    // return to application: reload pointer, master cleared to zero
    if (ret)
    begin
      state_next.master = 1'b0;
      state_next.redirect = 1'b1;
      state_next.redirect_ip = state_reg.saved_ptr;
    end
    // exception entry: save pointer, enter handler state, jump
    if (take)
    begin
      state_next.saved_ptr = exc_ip_in;
      state_next.master = 1'b1;
      state_next.redirect = 1'b1;
      state_next.redirect_ip = state_reg.entry_ptr;
    end
    // global entry pointer is loaded only by the system side
    if (handler_entry_load_in)
    begin
      state_next.entry_ptr = handler_entry_pointer_in;
    end
    // thread dispatch overrides masks, modes, enables, status, master and suppress for this thread
    if (dispatch_valid_in)
    begin
      state_next.disp_mask = dispatch_init_in.dispatch_channel_mask;
      state_next.vmask = grouped_mask;
      state_next.emask = dispatch_init_in.mask_select ? grouped_mask
        : dispatch_init_in.dispatch_channel_mask;
      state_next.round_mode = dispatch_init_in.round_mode;
      state_next.df_denorm_keep = dispatch_init_in.df_denorm_keep;
      state_next.mask_select = dispatch_init_in.mask_select;
      state_next.uniform_flow = dispatch_init_in.uniform_flow;
      state_next.single_float_behaviour = dispatch_init_in.single_float_behaviour;
      state_next.exc_enable = dispatch_init_in.exc_enable;
      state_next.exc_status = `RST_HALF;
      state_next.master = `RST_BIT;
      state_next.bp_suppress = `RST_BIT;
      state_next.accum_disable = `RST_BIT;
      state_next.redirect = 1'b0;
    end
  end

  // single register stage for the whole state
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      state_reg <= '0;
      state_reg.round_mode <= round_mode_t'(`RST_ROUND);
      state_reg.master <= `RST_BIT;
      state_reg.bp_suppress <= `RST_BIT;
      state_reg.accum_disable <= `RST_BIT;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // accumulator: explicit destination always writes, implicit one gated
  assign accum_write_enable_out = accum_explicit_dst_in
    || (accum_write_request_in && !state_reg.accum_disable);
  assign bp_pass_out = suppressing;
  assign arf_rdata_out = state_reg.rdata;
  assign arf_rvalid_out = state_reg.rvalid;
  assign redirect_out = state_reg.redirect;
  assign redirect_ip_out = state_reg.redirect_ip;
  assign master_exception_out = state_reg.master;
  assign exec_mask_out = state_reg.emask;

  // mode outputs straight from the stored fields, except denorm flush, which is the inverted keep bit
  always_comb
  begin
    exec_modes_out.round_mode = state_reg.round_mode;
    exec_modes_out.df_flush_denorm = !state_reg.df_denorm_keep;
    exec_modes_out.single_float_behaviour = state_reg.single_float_behaviour;
    exec_modes_out.uniform_flow = state_reg.uniform_flow;
    exec_modes_out.mask_select = state_reg.mask_select;
    exec_modes_out.accum_disable = state_reg.accum_disable;
  end

  // checks on the registered behaviour
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  a_entry_saves_ip: assert property (
    take && !dispatch_valid_in |=> redirect_out && master_exception_out
      && redirect_ip_out == $past(state_reg.entry_ptr) && state_reg.saved_ptr == $past(exc_ip_in))
    else $error("exception entry did not save pointer and jump");

  a_no_nested_jump: assert property (
    master_exception_out && !ret |=> !redirect_out)
    else $error("redirect taken while in handler state");

  a_disabled_no_jump: assert property (
    !master_exception_out && !ret && (evt & state_reg.exc_enable) == 16'h0000 |=> !redirect_out)
    else $error("redirect without an enabled event");

  a_status_records: assert property (
    exc_event_in[0] && !dispatch_valid_in |=> state_reg.exc_status[0])
    else $error("event not recorded in status");

  a_return_reloads: assert property (
    ret && !dispatch_valid_in |=> redirect_out && !master_exception_out
      && redirect_ip_out == $past(state_reg.saved_ptr))
    else $error("return did not reload saved pointer");

  a_master_write_one: assert property (
    hit_ctrl && wr && arf_req_in.sub_reg == `CTRL_SUB_GENERAL && !take && !dispatch_valid_in
      && arf_req_in.wdata[`BIT_MASTER_EXCEPTION] |=> $stable(master_exception_out))
    else $error("writing one changed master bit");

  a_suppress_passes: assert property (
    suppressing && !dispatch_valid_in && !(hit_ctrl && wr) |-> !evt[`EXC_IDX_BREAKPOINT]
      ##1 !state_reg.bp_suppress && !redirect_out)
    else $error("suppressed breakpoint still raised or suppress not cleared");

  a_suppress_ignored: assert property (
    bp_condition_in && (master_exception_out || !state_reg.exc_enable[`EXC_IDX_BREAKPOINT])
      && !(hit_ctrl && wr) && !dispatch_valid_in |-> !bp_pass_out
      ##1 state_reg.bp_suppress == $past(state_reg.bp_suppress))
    else $error("suppress honoured in handler state or with breakpoints off");

  a_accum_gate: assert property (
    state_reg.accum_disable && !accum_explicit_dst_in |-> !accum_write_enable_out)
    else $error("implicit accumulator update not blocked");

  a_dispatch_masks: assert property (
    dispatch_valid_in |=> exec_mask_out == ($past(dispatch_init_in.mask_select)
      ? state_reg.vmask : state_reg.disp_mask) && !master_exception_out)
    else $error("dispatch did not seed execution mask");

  a_read_latency: assert property (
    hit_ctrl && !wr && arf_req_in.sub_reg == `CTRL_SUB_SAVED_PTR |=> arf_rvalid_out
      && arf_rdata_out == $past(state_reg.saved_ptr))
    else $error("saved pointer read wrong");

  a_state_read: assert property (
    hit_state && !wr && arf_req_in.sub_reg == `STATE_SUB_DISPATCH_MASK |=> arf_rvalid_out
      && arf_rdata_out == $past(state_reg.disp_mask))
    else $error("dispatch mask read wrong");

  a_reserved_drop: assert property (
    hit_ctrl && wr && arf_req_in.sub_reg == `CTRL_SUB_RESERVED && !take && !dispatch_valid_in
      |=> state_reg.saved_ptr == $past(state_reg.saved_ptr) && $stable(exec_modes_out))
    else $error("write to reserved word changed state");

  a_bp_status: assert property (
    bp_condition_in && !bp_pass_out && !dispatch_valid_in |=> state_reg.exc_status[`EXC_IDX_BREAKPOINT])
    else $error("breakpoint not recorded in status");

  a_dispatch_clears: assert property (
    dispatch_valid_in |=> !redirect_out && !state_reg.bp_suppress && state_reg.exc_status == 16'h0000
      && exec_modes_out.round_mode == $past(dispatch_init_in.round_mode))
    else $error("dispatch did not load modes and clear state");

  c_exception_entry: cover property (take ##[1:20] ret);
  c_bp_suppressed: cover property (suppressing);
  c_event_in_handler: cover property (master_exception_out && |exc_event_in);
  c_reserved_write: cover property (hit_ctrl && wr && arf_req_in.sub_reg == `CTRL_SUB_RESERVED);
endmodule : thread_exception_control

// ---- dv/dispatch_pipeline_model.sv ----
// stand-in for the thread dispatcher and instruction pipeline around the control block
`timescale 1ns/1ps
module dispatch_pipeline_model
  import thread_exception_control_pkg::*;
(
  input wire logic clk_in,
  output logic dispatch_valid_out,
  output dispatch_init_t dispatch_init_out,
  output logic [15:0] exc_event_out,
  output logic bp_condition_out,
  output logic [31:0] exc_ip_out,
  output logic handler_entry_load_out,
  output logic [31:0] handler_entry_pointer_out
);
  // quiet lines at time zero: no dispatch, no events, no breakpoint and no handler load pending
  initial
  begin
    dispatch_valid_out = 1'b0;
    dispatch_init_out = '0;
    exc_event_out = 16'h0000;
    bp_condition_out = 1'b0;
    exc_ip_out = 32'h0000_0000;
    handler_entry_load_out = 1'b0;
    handler_entry_pointer_out = 32'h0000_0000;
  end

  // one-cycle dispatch; fields are inverted afterwards so stale values cannot pass
  task automatic dispatch(input dispatch_init_t init);
    @(negedge clk_in);
    dispatch_init_out = init;
    dispatch_valid_out = 1'b1;
    @(negedge clk_in);
    dispatch_valid_out = 1'b0;
    dispatch_init_out = dispatch_init_t'(~init);
  endtask : dispatch

  // system side loads the shared handler entry pointer
  task automatic load_handler(input logic [31:0] ptr);
    @(negedge clk_in);
    handler_entry_pointer_out = ptr;
    handler_entry_load_out = 1'b1;
    @(negedge clk_in);
    handler_entry_load_out = 1'b0;
    handler_entry_pointer_out = ~ptr;
  endtask : load_handler

  // raise events for the coming edge; quiet() ends them one cycle later
  task automatic fire(input logic [15:0] ev, input logic bp, input logic [31:0] ip);
    @(negedge clk_in);
    exc_event_out = ev;
    bp_condition_out = bp;
    exc_ip_out = ip;
  endtask : fire

  // the pointer line flips once released, so nothing latches it late
  task automatic quiet();
    @(negedge clk_in);
    exc_event_out = 16'h0000;
    bp_condition_out = 1'b0;
    exc_ip_out = ~exc_ip_out;
  endtask : quiet
endmodule : dispatch_pipeline_model

// ---- dv/thread_exception_control_tb.sv ----
// self-checking bench for the thread exception control block
`timescale 1ns/1ps
`include "thread_exception_control_consts.svh"
module thread_exception_control_tb
  import thread_exception_control_pkg::*;
;
  logic clk_in;
  logic srst_in;
  arf_req_t arf_req;
  logic [31:0] rdata;
  logic rvalid;
  logic acc_req;
  logic acc_dst;
  logic acc_we;
  logic bp_pass;
  logic redirect;
  logic [31:0] redirect_ip;
  logic master;
  logic [31:0] exec_mask;
  exec_modes_t modes;
  logic dsp_valid;
  dispatch_init_t dsp_init;
  logic [15:0] ev;
  logic bp;
  logic [31:0] ip;
  logic hload;
  logic [31:0] hptr;
  int mismatches;
  int check_count;

  thread_exception_control dut (.clk_in(clk_in), .srst_in(srst_in), .dispatch_valid_in(dsp_valid),
    .dispatch_init_in(dsp_init), .arf_req_in(arf_req), .arf_rdata_out(rdata), .arf_rvalid_out(rvalid),
    .exc_event_in(ev), .bp_condition_in(bp), .exc_ip_in(ip), .handler_entry_load_in(hload),
    .handler_entry_pointer_in(hptr), .accum_write_request_in(acc_req), .accum_explicit_dst_in(acc_dst),
    .accum_write_enable_out(acc_we), .bp_pass_out(bp_pass), .redirect_out(redirect),
    .redirect_ip_out(redirect_ip), .master_exception_out(master), .exec_mask_out(exec_mask),
    .exec_modes_out(modes));

  dispatch_pipeline_model model (.clk_in(clk_in), .dispatch_valid_out(dsp_valid), .dispatch_init_out(dsp_init),
    .exc_event_out(ev), .bp_condition_out(bp), .exc_ip_out(ip), .handler_entry_load_out(hload),
    .handler_entry_pointer_out(hptr));

  // 125 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic wrap_up();
    if (mismatches == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // one access per cycle; read answer is sampled the cycle after the taking edge
  task automatic reg_rd(input logic [3:0] rt, input logic [4:0] sub, input logic [31:0] exp, input string what);
    @(negedge clk_in);
    arf_req = '{valid: 1'b1, write: 1'b0, reg_type: rt, reg_num: `ARF_REGNUM_ZERO, sub_reg: sub, wdata: 32'h0};
    @(negedge clk_in);
    arf_req.valid = 1'b0;
    cmp({what, " rvalid"}, 32'h1, {31'h0, rvalid});
    cmp(what, exp, rdata);
  endtask : reg_rd

  task automatic reg_wr(input logic [4:0] sub, input logic [31:0] data);
    @(negedge clk_in);
    arf_req = '{valid: 1'b1, write: 1'b1, reg_type: `ARF_TYPE_CONTROL, reg_num: `ARF_REGNUM_ZERO, sub_reg: sub,
      wdata: data};
    @(negedge clk_in);
    arf_req.valid = 1'b0;
  endtask : reg_wr

  // event for one cycle, then the registered answer is looked at
  task automatic event_cycle(input logic [15:0] e, input logic b, input logic [31:0] p, input logic [31:0] pass_exp,
    input logic [31:0] redir_exp);
    model.fire(e, b, p);
    #1;
    cmp("bp_pass", pass_exp, {31'h0, bp_pass});
    model.quiet();
    cmp("redirect", redir_exp, {31'h0, redirect});
  endtask : event_cycle

  // watchdog: a hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    wrap_up();
  end

  initial
  begin
    arf_req = '0;
    acc_req = 1'b1;
    acc_dst = 1'b0;
    srst_in = 1'b1;
    mismatches = 0;
    check_count = 0;
    repeat (12) @(negedge clk_in);
    srst_in = 1'b0;
    cmp("master", 32'h0, {31'h0, master});
    cmp("modes", 32'h10, {25'h0, modes});
    reg_rd(`ARF_TYPE_CONTROL, `CTRL_SUB_GENERAL, 32'h0, "ctl_word");
    // dispatch: grouped nibbles, modes and enables loaded together
    model.dispatch('{32'h0010_F001, ROUND_DOWNWARD, 1'b1, 1'b1, 1'b1, 1'b1, 16'h8001});
    cmp("exec_mask", 32'h00F0_F00F, exec_mask);
    cmp("modes", 32'h4E, {25'h0, modes});
    reg_rd(`ARF_TYPE_STATE, `STATE_SUB_DISPATCH_MASK, 32'h0010_F001, "disp_mask");
    reg_rd(`ARF_TYPE_STATE, `STATE_SUB_GROUPED_MASK, 32'h00F0_F00F, "grouped");
    reg_rd(`ARF_TYPE_CONTROL, `CTRL_SUB_GENERAL, 32'h6D, "ctl_word");
    reg_rd(`ARF_TYPE_CONTROL, `CTRL_SUB_EXCEPTION, 32'h8001, "exc_word");
    // every rounding code, accumulator disable toggled alongside
    for (int r = 0; r < 4; r++)
    begin
      reg_wr(`CTRL_SUB_GENERAL, 32'h4D | (r << 4) | ((r & 1) << 1));
      cmp("round", r, {30'h0, modes.round_mode});
      cmp("accum_we", (r & 1) ? 32'h0 : 32'h1, {31'h0, acc_we});
    end
    acc_dst = 1'b1;
    #1;
    cmp("accum_we explicit", 32'h1, {31'h0, acc_we});
    reg_wr(`CTRL_SUB_GENERAL, 32'h4D);
    cmp("mask_select", 32'h1, {31'h0, modes.mask_select});
    reg_wr(`CTRL_SUB_RESERVED, 32'hA5A5_5A5A);
    reg_rd(`ARF_TYPE_CONTROL, `CTRL_SUB_RESERVED, 32'h0, "reserved");
    reg_rd(`ARF_TYPE_CONTROL, 5'h10, 32'h0, "unknown sub");
    // enabled event enters the handler
    model.load_handler(32'h0000_4000);
    event_cycle(16'h0001, 1'b0, 32'h0000_0100, 32'h0, 32'h1);
    cmp("redirect_ip", 32'h0000_4000, redirect_ip);
    cmp("master", 32'h1, {31'h0, master});
    reg_rd(`ARF_TYPE_CONTROL, `CTRL_SUB_SAVED_PTR, 32'h0000_0100, "saved_ptr");
    reg_rd(`ARF_TYPE_CONTROL, `CTRL_SUB_EXCEPTION, 32'h0001_8001, "exc_word");
    // in the handler events only mark status, disabled ones too
    event_cycle(16'h0009, 1'b0, 32'h0000_0200, 32'h0, 32'h0);
    reg_rd(`ARF_TYPE_CONTROL, `CTRL_SUB_EXCEPTION, 32'h0009_8001, "exc_word");
    reg_rd(`ARF_TYPE_CONTROL, `CTRL_SUB_SAVED_PTR, 32'h0000_0100, "saved_ptr");
    reg_wr(`CTRL_SUB_GENERAL, 32'h8000_004D);
    cmp("master", 32'h1, {31'h0, master});
    // handler clears status, then sets suppress in the same write that returns
    reg_wr(`CTRL_SUB_EXCEPTION, 32'h0000_8001);
    reg_wr(`CTRL_SUB_GENERAL, 32'h0000_804D);
    cmp("return redirect", 32'h1, {31'h0, redirect});
    cmp("return ip", 32'h0000_0100, redirect_ip);
    cmp("master", 32'h0, {31'h0, master});
    // suppressed breakpoint runs once, suppress self-clears
    event_cycle(16'h0000, 1'b1, 32'h0000_0300, 32'h1, 32'h0);
    reg_rd(`ARF_TYPE_CONTROL, `CTRL_SUB_GENERAL, 32'h4D, "ctl_word");
    reg_rd(`ARF_TYPE_CONTROL, `CTRL_SUB_EXCEPTION, 32'h0000_8001, "exc_word");
    event_cycle(16'h0000, 1'b1, 32'h0000_0300, 32'h0, 32'h1);
    reg_rd(`ARF_TYPE_CONTROL, `CTRL_SUB_EXCEPTION, 32'h8000_8001, "exc_word");
    // suppress has no effect inside the handler
    reg_wr(`CTRL_SUB_GENERAL, 32'h8000_804D);
    event_cycle(16'h0000, 1'b1, 32'h0000_0400, 32'h0, 32'h0);
    // return, then breakpoints disabled: suppress ignored and kept
    reg_wr(`CTRL_SUB_GENERAL, 32'h0000_804D);
    reg_wr(`CTRL_SUB_EXCEPTION, 32'h0000_0001);
    event_cycle(16'h0000, 1'b1, 32'h0000_0500, 32'h0, 32'h0);
    reg_rd(`ARF_TYPE_CONTROL, `CTRL_SUB_EXCEPTION, 32'h8000_0001, "exc_word");
    reg_rd(`ARF_TYPE_CONTROL, `CTRL_SUB_GENERAL, 32'h804D, "ctl_word");
    // second dispatch with the plain mask; suppress and status must not survive it
    model.dispatch('{32'h0300_0080, ROUND_UPWARD, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0002});
    cmp("exec_mask", 32'h0300_0080, exec_mask);
    cmp("modes", 32'h30, {25'h0, modes});
    reg_rd(`ARF_TYPE_STATE, `STATE_SUB_GROUPED_MASK, 32'h0F00_00F0, "grouped");
    reg_rd(`ARF_TYPE_CONTROL, `CTRL_SUB_GENERAL, 32'h10, "ctl_word");
    reg_rd(`ARF_TYPE_CONTROL, `CTRL_SUB_EXCEPTION, 32'h0000_0002, "exc_word");
    wrap_up();
  end
endmodule : thread_exception_control_tb
